// File: include/bru_pkg.sv
package bru_pkg;

   localparam int BRU_DATA_W = 8;
   localparam int BRU_ADDR_W = 8;
   localparam int BRU_MSB = 7;
   localparam int BRU_LSB = 0;

   // Values after reset
   localparam logic [7:0] BRU_ACC_RST = 8'h00;
   localparam logic [7:0] BRU_ADDR_RST = 8'h00;
   localparam logic [7:0] BRU_WDATA_RST = 8'h00;
   localparam logic BRU_FLAG_RST = 1'b0;

   // Cycles from request edge to result visible on the outputs
   localparam int BRU_OP_CYCLES = 1;

   typedef enum logic [2:0] {
      BRU_OP_NONE,
      ROTATE_LEFT_VIA_CARRY,
      ROTATE_LEFT_VIA_CARRY_TO_ACC,
      ROTATE_RIGHT_PLAIN,
      ROTATE_RIGHT_PLAIN_TO_ACC,
      ROTATE_RIGHT_VIA_CARRY,
      ROTATE_RIGHT_VIA_CARRY_TO_ACC
   } bru_op_e;

   typedef struct packed {
      bru_op_e op;
      logic [7:0] addr;
   } bru_req_s;

   typedef struct packed {
      logic ov;
      logic z;
      logic ac;
      logic c;
   } bru_flags_s;

   localparam bru_flags_s BRU_FLAGS_RST = '{ov: 1'b0, z: 1'b0, ac: 1'b0, c: 1'b0};

endpackage

// File: verilog/bru_rotator.sv
`timescale 1ns/1ps
`default_nettype none

module bru_rotator
   import bru_pkg::*;
(
   // Operation
   input wire bru_op_e op_i,
   input wire logic [7:0] data_i,
   input wire logic carry_i,
   // Result
   output logic [7:0] result_o,
   output logic carry_o,
   output logic carry_we_o,
   output logic to_acc_o,
   output logic valid_op_o
);

   wire logic is_left;
   wire logic is_plain;
   wire logic [7:0] left_via_carry;
   wire logic [7:0] right_plain;
   wire logic [7:0] right_via_carry;

   assign is_left = (op_i == ROTATE_LEFT_VIA_CARRY) || (op_i == ROTATE_LEFT_VIA_CARRY_TO_ACC);
   assign is_plain = (op_i == ROTATE_RIGHT_PLAIN) || (op_i == ROTATE_RIGHT_PLAIN_TO_ACC);

   // Bits 0..6 move up one place and bits 1..7 move down one place
   genvar i;
   generate
      for (i = 0; i < BRU_MSB; i = i + 1) begin : g_shift
         assign left_via_carry[i + 1] = data_i[i];
         assign right_plain[i] = data_i[i + 1];
         assign right_via_carry[i] = data_i[i + 1];
      end
   endgenerate

   assign left_via_carry[BRU_LSB] = carry_i;
   assign right_plain[BRU_MSB] = data_i[BRU_LSB];
   assign right_via_carry[BRU_MSB] = carry_i;

   assign result_o = is_left ? left_via_carry : (is_plain ? right_plain : right_via_carry);
   assign carry_o = is_left ? data_i[BRU_MSB] : data_i[BRU_LSB];
   // Plain rotates never touch the carry
   assign carry_we_o = valid_op_o && !is_plain;
   assign to_acc_o = (op_i == ROTATE_LEFT_VIA_CARRY_TO_ACC) || (op_i == ROTATE_RIGHT_PLAIN_TO_ACC) ||
                     (op_i == ROTATE_RIGHT_VIA_CARRY_TO_ACC);
   assign valid_op_o = (op_i != BRU_OP_NONE) && (op_i <= ROTATE_RIGHT_VIA_CARRY_TO_ACC);

endmodule // bru_rotator

`default_nettype wire

// File: verilog/bru_rotate_unit.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Left via carry: byte shifts left, old carry to bit 0, bit 7 to carry, written back.
// - Left via carry to acc: same result into accumulator, carry from bit 7, memory untouched.
// - Right plain: bit 0 wraps to bit 7, written back, no flag changes.
// - Right plain to acc: rotated byte into accumulator, memory and all flags untouched.
// - Right via carry: old carry to bit 7, bit 0 to carry, written back.
// - Right via carry to acc: result into accumulator, carry from bit 0, memory untouched.
// - Through-carry rotates change carry only; every other flag keeps its value.

module bru_rotate_unit
   import bru_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Rotate request from the decoder
   input wire logic req_valid_i,
   input wire bru_req_s req_i,
   // Data memory read path, byte at req_i.addr in the same cycle
   input wire logic [7:0] mem_rdata_i,
   // Accumulator and status loads by other instructions
   input wire logic acc_wr_i,
   input wire logic [7:0] acc_wdata_i,
   input wire logic flags_wr_i,
   input wire bru_flags_s flags_wdata_i,
   // Data memory write path
   output logic mem_we_o,
   output logic [7:0] mem_addr_o,
   output logic [7:0] mem_wdata_o,
   // Core state
   output logic [7:0] acc_o,
   output bru_flags_s flags_o,
   output logic done_o
);

   logic [7:0] acc_r;
   logic [7:0] acc_nxt;
   bru_flags_s flags_r;
   bru_flags_s flags_nxt;
   logic mem_we_r;
   logic [7:0] mem_addr_r;
   logic [7:0] mem_wdata_r;
   logic done_r;

   wire logic [7:0] rot_result;
   wire logic rot_carry;
   wire logic rot_carry_we;
   wire logic rot_to_acc;
   wire logic rot_valid;
   wire logic go;
   wire logic go_mem;
   wire logic go_acc;
   wire logic go_carry;

   bru_rotator u_rotator (
      .op_i(req_i.op),
      .data_i(mem_rdata_i),
      .carry_i(flags_r.c),
      .result_o(rot_result),
      .carry_o(rot_carry),
      .carry_we_o(rot_carry_we),
      .to_acc_o(rot_to_acc),
      .valid_op_o(rot_valid)
   );

   // A rotate is taken in the cycle it is requested and finishes at that edge
   assign go = req_valid_i && rot_valid;
   assign go_mem = go && !rot_to_acc;
   assign go_acc = go && rot_to_acc;
   assign go_carry = go && rot_carry_we;

   // An accumulator-form rotate wins over an external accumulator load in the same cycle
   assign acc_nxt = go_acc ? rot_result : (acc_wr_i ? acc_wdata_i : acc_r);

   // Only the carry bit is ever written by a rotate; ov, z and ac pass through
   always_comb begin
      flags_nxt = flags_wr_i ? flags_wdata_i : flags_r;
      if (go) begin
         flags_nxt = flags_r;
      end
      if (go_carry) begin
         flags_nxt.c = rot_carry;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         acc_r <= BRU_ACC_RST;
         flags_r <= BRU_FLAGS_RST;
      end else begin
         acc_r <= acc_nxt;
         flags_r <= flags_nxt;
      end
   end

   // Memory write strobe is a one-cycle pulse after the request edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mem_we_r <= BRU_FLAG_RST;
         mem_addr_r <= BRU_ADDR_RST;
         mem_wdata_r <= BRU_WDATA_RST;
         done_r <= BRU_FLAG_RST;
      end else begin
         mem_we_r <= go_mem;
         mem_addr_r <= go ? req_i.addr : mem_addr_r;
         mem_wdata_r <= go_mem ? rot_result : mem_wdata_r;
         done_r <= go;
      end
   end

   assign mem_we_o = mem_we_r;
   assign mem_addr_o = mem_addr_r;
   assign mem_wdata_o = mem_wdata_r;
   assign acc_o = acc_r;
   assign flags_o = flags_r;
   assign done_o = done_r;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // Checks decode the request on their own rather than reuse the rotator decode,
   // so a slip in that decode cannot hide behind its own checks
   wire logic req_rotate;
   wire logic req_to_acc;
   assign req_rotate = req_valid_i && (req_i.op inside {ROTATE_LEFT_VIA_CARRY, ROTATE_LEFT_VIA_CARRY_TO_ACC,
      ROTATE_RIGHT_PLAIN, ROTATE_RIGHT_PLAIN_TO_ACC, ROTATE_RIGHT_VIA_CARRY, ROTATE_RIGHT_VIA_CARRY_TO_ACC});
   assign req_to_acc = req_valid_i && (req_i.op inside {ROTATE_LEFT_VIA_CARRY_TO_ACC, ROTATE_RIGHT_PLAIN_TO_ACC,
      ROTATE_RIGHT_VIA_CARRY_TO_ACC});

   a_left_carry_mem: assert property (
      (req_valid_i && req_i.op == ROTATE_LEFT_VIA_CARRY) |=>
         (mem_we_o && mem_wdata_o == {$past(mem_rdata_i[6:0]), $past(flags_o.c)} &&
          flags_o.c == $past(mem_rdata_i[7]) && mem_addr_o == $past(req_i.addr)))
      else $error("left rotate via carry wrote wrong byte or carry");

   a_left_carry_acc: assert property (
      (req_valid_i && req_i.op == ROTATE_LEFT_VIA_CARRY_TO_ACC) |=>
         (!mem_we_o && acc_o == {$past(mem_rdata_i[6:0]), $past(flags_o.c)} &&
          flags_o.c == $past(mem_rdata_i[7])))
      else $error("left rotate via carry to acc wrong");

   a_right_plain_mem: assert property (
      (req_valid_i && req_i.op == ROTATE_RIGHT_PLAIN) |=>
         (mem_we_o && mem_wdata_o == {$past(mem_rdata_i[0]), $past(mem_rdata_i[7:1])} &&
          $stable(flags_o)))
      else $error("plain right rotate wrong or flags changed");

   a_right_plain_acc: assert property (
      (req_valid_i && req_i.op == ROTATE_RIGHT_PLAIN_TO_ACC) |=>
         (!mem_we_o && $stable(flags_o) &&
          acc_o == {$past(mem_rdata_i[0]), $past(mem_rdata_i[7:1])}))
      else $error("plain right rotate to acc wrong");

   a_right_carry_mem: assert property (
      (req_valid_i && req_i.op == ROTATE_RIGHT_VIA_CARRY) |=>
         (mem_we_o && mem_wdata_o == {$past(flags_o.c), $past(mem_rdata_i[7:1])} &&
          flags_o.c == $past(mem_rdata_i[0])))
      else $error("right rotate via carry wrote wrong byte or carry");

   a_right_carry_acc: assert property (
      (req_valid_i && req_i.op == ROTATE_RIGHT_VIA_CARRY_TO_ACC) |=>
         (!mem_we_o && acc_o == {$past(flags_o.c), $past(mem_rdata_i[7:1])} &&
          flags_o.c == $past(mem_rdata_i[0])))
      else $error("right rotate via carry to acc wrong");

   a_other_flags_keep: assert property (
      (req_valid_i && req_i.op != BRU_OP_NONE) |=>
         (flags_o.ov == $past(flags_o.ov) && flags_o.z == $past(flags_o.z) &&
          flags_o.ac == $past(flags_o.ac)))
      else $error("rotate changed a flag other than carry");

   a_one_cycle_done: assert property (
      (req_valid_i && req_i.op != BRU_OP_NONE) |=> done_o ##1 (!done_o || $past(req_valid_i)))
      else $error("rotate did not finish in one cycle");

   a_mem_untouched: assert property (
      req_to_acc |=>
         (!mem_we_o && $stable(mem_wdata_o)))
      else $error("accumulator rotate disturbed the memory write path");

   a_addr_follows: assert property (
      req_rotate |=>
         (done_o && mem_addr_o == $past(req_i.addr)))
      else $error("rotate did not latch its address");

   // An empty or unknown op must leave the memory side quiet
   a_idle_quiet: assert property (
      (!req_rotate) |=>
         (!done_o && !mem_we_o && $stable(mem_addr_o) && $stable(mem_wdata_o)))
      else $error("memory strobe or done without a rotate");

   a_mem_we_pulse: assert property (
      mem_we_o |->
         done_o)
      else $error("memory strobe without done");

   // Outside an accumulator rotate the external accumulator load goes through
   a_acc_load: assert property (
      (acc_wr_i && !req_to_acc) |=>
         (acc_o == $past(acc_wdata_i)))
      else $error("external accumulator load lost");

   // Without an external load, memory-form rotates and idle cycles hold the accumulator
   a_acc_hold: assert property (
      (!acc_wr_i && !req_to_acc) |=>
         $stable(acc_o))
      else $error("accumulator changed without a load");

   // A rotate cycle drops a same-cycle status load; otherwise the load lands
   a_flags_load: assert property (
      (flags_wr_i && !req_rotate) |=>
         (flags_o == $past(flags_wdata_i)))
      else $error("external status load lost");

   a_flags_hold: assert property (
      (!flags_wr_i && !req_rotate) |=>
         $stable(flags_o))
      else $error("status changed without a load or rotate");

endmodule // bru_rotate_unit

`default_nettype wire

// File: verif/bru_rotate_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none

module bru_rotate_unit_bench
   import bru_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic req_valid_i = 1'b0;
   bru_req_s req_i = '{op: BRU_OP_NONE, addr: 8'h00};
   logic [7:0] mem_rdata_i = 8'h00;
   logic acc_wr_i = 1'b0;
   logic [7:0] acc_wdata_i = 8'h00;
   logic flags_wr_i = 1'b0;
   bru_flags_s flags_wdata_i = BRU_FLAGS_RST;
   logic mem_we_o;
   logic done_o;
   logic [7:0] mem_addr_o;
   logic [7:0] mem_wdata_o;
   logic [7:0] acc_o;
   bru_flags_s flags_o;
   int n_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   logic [7:0] acc_m = BRU_ACC_RST;
   bru_flags_s flags_m = BRU_FLAGS_RST;

   bru_rotate_unit i_bru_rotate_unit (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_i(req_i),
      .mem_rdata_i(mem_rdata_i), .acc_wr_i(acc_wr_i), .acc_wdata_i(acc_wdata_i), .flags_wr_i(flags_wr_i),
      .flags_wdata_i(flags_wdata_i), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
      .acc_o(acc_o), .flags_o(flags_o), .done_o(done_o));

   initial begin
      forever #12.5 clk_i = ~clk_i;
   end

   task automatic tally_and_finish();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Returns {carry, result}
   function automatic logic [8:0] model(input bru_op_e op, input logic [7:0] d, input logic c);
      case (op)
         ROTATE_LEFT_VIA_CARRY, ROTATE_LEFT_VIA_CARRY_TO_ACC: model = {d[7], d[6:0], c};
         ROTATE_RIGHT_VIA_CARRY, ROTATE_RIGHT_VIA_CARRY_TO_ACC: model = {d[0], c, d[7:1]};
         default: model = {c, d[0], d[7:1]};
      endcase
   endfunction

   // Called at a rising edge; returns at the edge that takes the request
   task automatic rot(input bru_op_e op, input logic [7:0] a, input logic [7:0] d, input logic last);
      logic [8:0] r;
      logic to_acc;
      logic [7:0] acc_x;
      bru_flags_s fl_x;
      r = model(op, d, flags_m.c);
      to_acc = op inside {ROTATE_LEFT_VIA_CARRY_TO_ACC, ROTATE_RIGHT_PLAIN_TO_ACC, ROTATE_RIGHT_VIA_CARRY_TO_ACC};
      if (to_acc) acc_m = r[7:0];
      if (!(op inside {ROTATE_RIGHT_PLAIN, ROTATE_RIGHT_PLAIN_TO_ACC})) flags_m.c = r[8];
      acc_x = acc_m;
      fl_x = flags_m;
      req_valid_i <= 1'b1;
      req_i <= '{op: op, addr: a};
      mem_rdata_i <= d;
      @(posedge clk_i);
      if (last) begin
         req_valid_i <= 1'b0;
         mem_rdata_i <= ~d;
      end
      fork
         begin
            #1;
            cmp(8'(done_o), 8'h01);
            cmp(8'(mem_we_o), 8'(!to_acc));
            cmp(mem_addr_o, a);
            if (!to_acc) cmp(mem_wdata_o, r[7:0]);
            cmp(acc_o, acc_x);
            cmp(8'(flags_o), 8'(fl_x));
         end
      join_none
   endtask

   task automatic t_reset();
      cmp(acc_o, BRU_ACC_RST);
      cmp(8'(flags_o), 8'(BRU_FLAGS_RST));
      cmp(8'(done_o), 8'h00);
      cmp(8'(mem_we_o), 8'h00);
      cmp(mem_addr_o, BRU_ADDR_RST);
      cmp(mem_wdata_o, BRU_WDATA_RST);
   endtask

   // All six back to back, each on the carry left by the one before
   task automatic t_each_op();
      @(posedge clk_i);
      flags_wr_i <= 1'b1;
      flags_wdata_i <= '{ov: 1'b1, z: 1'b1, ac: 1'b1, c: 1'b1};
      @(posedge clk_i);
      flags_wr_i <= 1'b0;
      flags_m = '{ov: 1'b1, z: 1'b1, ac: 1'b1, c: 1'b1};
      rot(ROTATE_LEFT_VIA_CARRY, 8'h10, 8'h41, 1'b0);
      rot(ROTATE_LEFT_VIA_CARRY_TO_ACC, 8'h11, 8'hda, 1'b0);
      rot(ROTATE_RIGHT_PLAIN, 8'h12, 8'h01, 1'b0);
      rot(ROTATE_RIGHT_PLAIN_TO_ACC, 8'h13, 8'hc3, 1'b0);
      rot(ROTATE_RIGHT_VIA_CARRY, 8'h14, 8'h02, 1'b0);
      rot(ROTATE_RIGHT_VIA_CARRY_TO_ACC, 8'hff, 8'h7f, 1'b1);
      @(posedge clk_i);
   endtask

   // Rotate beats same-cycle loads; an empty op leaves memory and status alone but lets the accumulator load land
   task automatic t_refuse();
      @(posedge clk_i);
      acc_wr_i <= 1'b1;
      acc_wdata_i <= 8'hee;
      flags_wr_i <= 1'b1;
      flags_wdata_i <= BRU_FLAGS_RST;
      rot(ROTATE_RIGHT_PLAIN_TO_ACC, 8'h44, 8'h03, 1'b0);
      flags_wr_i <= 1'b0;
      req_i <= '{op: BRU_OP_NONE, addr: 8'h55};
      @(posedge clk_i);
      req_valid_i <= 1'b0;
      acc_wr_i <= 1'b0;
      #1;
      cmp(8'(done_o), 8'h00);
      cmp(8'(mem_we_o), 8'h00);
      cmp(acc_o, 8'hee);
      cmp(mem_addr_o, 8'h44);
      cmp(8'(flags_o), 8'(flags_m));
      acc_m = 8'hee;
   endtask

   // Reset wins over a rotate in the same cycle; the first edge after release takes a rotate
   task automatic t_mid_reset();
      @(posedge clk_i);
      rst_i <= 1'b1;
      req_valid_i <= 1'b1;
      req_i <= '{op: ROTATE_LEFT_VIA_CARRY, addr: 8'h66};
      mem_rdata_i <= 8'h80;
      @(posedge clk_i);
      req_valid_i <= 1'b0;
      #1;
      t_reset();
      @(posedge clk_i);
      rst_i <= 1'b0;
      acc_m = BRU_ACC_RST;
      flags_m = BRU_FLAGS_RST;
      rot(ROTATE_LEFT_VIA_CARRY, 8'h21, 8'h80, 1'b1);
      @(posedge clk_i);
   endtask

   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      t_reset();
      t_each_op();
      t_refuse();
      t_mid_reset();
      repeat (3) @(posedge clk_i);
      tally_and_finish();
   end

   // Whole run needs about 22 cycles
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 500) begin
         n_errors++;
         tally_and_finish();
      end
   end
endmodule // bru_rotate_unit_bench

`default_nettype wire
